// ### hdl/pwm_array_pkg.sv
// Purpose: shared constants and types for the counter array pwm block
// Assumes: 32-bit avalon-mm register bus, byte-wide registers in the low lane
// Notes:   one register word per 4-byte address, unused bits read as zero
`default_nettype none

package pwm_array_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_MODULES = 4;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] OFF_COUNTER_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COUNTER_LOW     = 8'h04;
  localparam logic [7:0] OFF_COUNTER_HIGH    = 8'h08;
  localparam logic [7:0] OFF_PIN_STATUS      = 8'h0c;
  // module m sits in slot m+1, one 16-byte slot each
  localparam logic [3:0] OFF_MODE            = 4'h0;
  localparam logic [3:0] OFF_COMPARE_LOW     = 4'h4;
  localparam logic [3:0] OFF_COMPARE_HIGH    = 4'h8;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int         CTL_RUN_BIT      = 0;
  localparam int         CTL_TB_LSB       = 1;
  localparam int         MODE_PWM_BIT     = 1;
  localparam int         MODE_ECOM_BIT    = 6;
  localparam logic [7:0] BYTE_ZERO        = 8'h00;
  localparam logic [7:0] BYTE_WRAP        = 8'hff;
  localparam logic [3:0] PRESCALE_LAST    = 4'hb;
  localparam logic [1:0] DIV4_PHASE       = 2'h3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    TB_SYSCLK  = 2'h0,
    TB_DIV4    = 2'h1,
    TB_DIV12   = 2'h2,
    TB_EXTERN  = 2'h3
  } timebase_t;

  typedef struct packed {
    logic comparator_enable_bit;
    logic pwm_mode_bit;
  } mode_t;

  localparam mode_t MODE_RESET = '{comparator_enable_bit: 1'b0, pwm_mode_bit: 1'b0};

  typedef struct packed {
    logic [7:0] counter_low_byte;
    logic [7:0] counter_high_byte;
  } counter_array_t;

endpackage

`default_nettype wire

// ### hdl/pwm_array.sv
// Purpose: shared 16-bit counter array with per-module 8-bit pwm outputs
// Assumes: avalon-mm slave with one wait state, synchronous active-high reset
// Notes:   external timebase pin is synchronised before use
//
// Functional notes
// - each module drives its own pwm pin independently of the others
// - pwm frequency comes only from the shared counter timebase
// - counter low byte equal to compare low byte drives pin high
// - counter low byte overflow drives the pin low
// - in pwm mode, on overflow compare low byte reloads from compare high byte
// - pwm mode needs comparator enable and pwm mode bits both set
// - compare low write clears comparator enable, compare high write sets it
// - duty cycle equals (255 minus compare high byte) over 256 with the clk timebase
`timescale 1ns/1ps
`default_nettype none

module pwm_array (
  input  wire logic                                   clk,
  input  wire logic                                   srst,
  input  wire logic [pwm_array_pkg::ADDR_W-1:0]       avs_address,
  input  wire logic                                   avs_read,
  input  wire logic                                   avs_write,
  input  wire logic [pwm_array_pkg::DATA_W-1:0]       avs_writedata,
  input  wire logic [3:0]                             avs_byteenable,
  input  wire logic                                   ext_tick_pin,
  output var  logic [pwm_array_pkg::DATA_W-1:0]       avs_readdata,
  output logic                                        avs_waitrequest,
  output var  logic [pwm_array_pkg::NUM_MODULES-1:0]  module_output_pin
);

  // ****************************************************************
  // bus slave handshake
  // ****************************************************************
  // one wait state: request seen, answer on the following edge
  logic       ack;
  wire logic  req;
  wire logic  wr_go;
  wire logic  rd_load;
  wire logic  lane0;
  wire logic  [7:0] wdata;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign lane0           = avs_byteenable[0];
  assign wr_go           = avs_write & ack & lane0;
  assign rd_load         = avs_read & ~ack;
  assign wdata           = avs_writedata[7:0];

  always_ff @(posedge clk) begin
    if (srst) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // ****************************************************************
  // counter control and timebase
  // ****************************************************************
  logic                       counter_run;
  pwm_array_pkg::timebase_t   timebase_sel;
  logic [3:0]                 prescale_count;
  logic                       ext_meta;
  logic                       ext_sync;
  logic                       ext_prev;
  pwm_array_pkg::counter_array_t counter_array;

  wire logic wr_ctl;
  wire logic wr_cnt_low;
  wire logic wr_cnt_high;
  wire logic ext_tick;
  wire logic tb_tick;
  wire logic tick;
  wire logic overflow;

  assign wr_ctl      = wr_go & (avs_address == pwm_array_pkg::OFF_COUNTER_CONTROL);
  assign wr_cnt_low  = wr_go & (avs_address == pwm_array_pkg::OFF_COUNTER_LOW);
  assign wr_cnt_high = wr_go & (avs_address == pwm_array_pkg::OFF_COUNTER_HIGH);
  assign ext_tick    = ext_sync & ~ext_prev;

  assign tb_tick = (timebase_sel == pwm_array_pkg::TB_SYSCLK) ? 1'b1 :
                   (timebase_sel == pwm_array_pkg::TB_DIV4)
                     ? (prescale_count[1:0] == pwm_array_pkg::DIV4_PHASE) :
                   (timebase_sel == pwm_array_pkg::TB_DIV12)
                     ? (prescale_count == pwm_array_pkg::PRESCALE_LAST) :
                   ext_tick;
  assign tick     = counter_run & tb_tick;
  assign overflow = tick & (counter_array.counter_low_byte == pwm_array_pkg::BYTE_WRAP);

  always_ff @(posedge clk) begin
    if (srst) begin
      counter_run  <= 1'b0;
      timebase_sel <= pwm_array_pkg::TB_SYSCLK;
    end else if (wr_ctl) begin
      counter_run  <= wdata[pwm_array_pkg::CTL_RUN_BIT];
      timebase_sel <= pwm_array_pkg::timebase_t'(wdata[pwm_array_pkg::CTL_TB_LSB +: 2]);
    end
  end

  // mod-12 prescaler shared by divide-by-4 and divide-by-12
  always_ff @(posedge clk) begin
    if (srst) begin
      prescale_count <= 4'h0;
    end else if (prescale_count == pwm_array_pkg::PRESCALE_LAST) begin
      prescale_count <= 4'h0;
    end else begin
      prescale_count <= prescale_count + 4'h1;
    end
  end

  // pin is asynchronous: two flops before the edge detector
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_tick_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      counter_array.counter_low_byte <= pwm_array_pkg::BYTE_ZERO;
    end else if (wr_cnt_low) begin
      counter_array.counter_low_byte <= wdata;
    end else if (tick) begin
      counter_array.counter_low_byte <= counter_array.counter_low_byte + 8'h01;
    end
  end

  // high byte carries low-byte overflow; a software write wins
  always_ff @(posedge clk) begin
    if (srst) begin
      counter_array.counter_high_byte <= pwm_array_pkg::BYTE_ZERO;
    end else if (wr_cnt_high) begin
      counter_array.counter_high_byte <= wdata;
    end else if (overflow) begin
      counter_array.counter_high_byte <= counter_array.counter_high_byte + 8'h01;
    end
  end

  // ****************************************************************
  // pwm modules
  // ****************************************************************
  logic [7:0] rd_chain [pwm_array_pkg::NUM_MODULES+1];

  assign rd_chain[0] = 8'h00;

  for (genvar g = 0; g < pwm_array_pkg::NUM_MODULES; g++) begin : gen_module
    localparam logic [3:0] SLOT = 4'(g + 1);

    pwm_array_pkg::mode_t module_mode_register;
    logic [7:0]           compare_low_byte;
    logic [7:0]           compare_high_byte;

    wire logic       sel;
    wire logic       wr_mode;
    wire logic       wr_cmp_low;
    wire logic       wr_cmp_high;
    wire logic       pwm_on;
    wire logic       match;
    wire logic [7:0] mode_byte;
    wire logic [7:0] rd_byte;

    assign sel         = (avs_address[7:4] == SLOT);
    assign wr_mode     = wr_go & sel & (avs_address[3:0] == pwm_array_pkg::OFF_MODE);
    assign wr_cmp_low  = wr_go & sel & (avs_address[3:0] == pwm_array_pkg::OFF_COMPARE_LOW);
    assign wr_cmp_high = wr_go & sel & (avs_address[3:0] == pwm_array_pkg::OFF_COMPARE_HIGH);
    assign pwm_on      = module_mode_register.comparator_enable_bit &
                         module_mode_register.pwm_mode_bit;
    assign match       = (counter_array.counter_low_byte == compare_low_byte);

    assign mode_byte = {1'b0, module_mode_register.comparator_enable_bit, 4'h0,
                        module_mode_register.pwm_mode_bit, 1'b0};
    assign rd_byte   = ~sel ? 8'h00 :
                       (avs_address[3:0] == pwm_array_pkg::OFF_MODE)         ? mode_byte :
                       (avs_address[3:0] == pwm_array_pkg::OFF_COMPARE_LOW)  ? compare_low_byte :
                       (avs_address[3:0] == pwm_array_pkg::OFF_COMPARE_HIGH) ? compare_high_byte :
                       8'h00;
    assign rd_chain[g+1] = rd_chain[g] | rd_byte;

    always_ff @(posedge clk) begin
      if (srst) begin
        module_mode_register <= pwm_array_pkg::MODE_RESET;
      end else if (wr_mode) begin
        module_mode_register <= '{comparator_enable_bit: wdata[pwm_array_pkg::MODE_ECOM_BIT],
                                  pwm_mode_bit:          wdata[pwm_array_pkg::MODE_PWM_BIT]};
      end else if (wr_cmp_low) begin
        module_mode_register.comparator_enable_bit <= 1'b0;
      end else if (wr_cmp_high) begin
        module_mode_register.comparator_enable_bit <= 1'b1;
      end
    end

    // software write beats the reload so a fresh value is never lost
    always_ff @(posedge clk) begin
      if (srst) begin
        compare_low_byte <= pwm_array_pkg::BYTE_ZERO;
      end else if (wr_cmp_low) begin
        compare_low_byte <= wdata;
      end else if (pwm_on & overflow) begin
        compare_low_byte <= compare_high_byte;
      end
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        compare_high_byte <= pwm_array_pkg::BYTE_ZERO;
      end else if (wr_cmp_high) begin
        compare_high_byte <= wdata;
      end
    end

    // high from the clock after match to overflow gives (255-high)/256 on the clk timebase
    always_ff @(posedge clk) begin
      if (srst) begin
        module_output_pin[g] <= 1'b0;
      end else if (~pwm_on) begin
        module_output_pin[g] <= 1'b0;
      end else if (overflow) begin
        module_output_pin[g] <= 1'b0;
      end else if (match) begin
        module_output_pin[g] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  wire logic [7:0] ctl_byte;
  wire logic [7:0] pin_byte;
  wire logic [7:0] rd_value;

  assign ctl_byte = {5'h00, timebase_sel, counter_run};
  assign pin_byte = 8'(module_output_pin);
  assign rd_value = (avs_address == pwm_array_pkg::OFF_COUNTER_CONTROL) ? ctl_byte :
                    (avs_address == pwm_array_pkg::OFF_COUNTER_LOW)
                      ? counter_array.counter_low_byte :
                    (avs_address == pwm_array_pkg::OFF_COUNTER_HIGH)
                      ? counter_array.counter_high_byte :
                    (avs_address == pwm_array_pkg::OFF_PIN_STATUS) ? pin_byte :
                    rd_chain[pwm_array_pkg::NUM_MODULES];

  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_load) begin
      avs_readdata <= {24'h00_0000, rd_value};
    end
  end

endmodule // pwm_array

`default_nettype wire

// ### test/pwm_array_asserts.sv
// Purpose: port-level checks for the pwm counter array
// Assumes: one wait state per bus request
// Notes:   module 0 stands in for every pwm pin in the compare low and mode off checks
`timescale 1ns/1ps
`default_nettype none
module pwm_array_asserts (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [3:0]  module_output_pin
);
  // ********************
  // checks
  // ********************
  wire logic req = avs_read | avs_write;
  wire logic wack = avs_write & ~avs_waitrequest & avs_byteenable[0];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_wait_first:
    assert property (req && !$past(req) |-> avs_waitrequest) else $error("no wait on new request");
  chk_wait_one:
    assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("second wait cycle");
  chk_read_upper:
    assert property (avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_read_hold:
    assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
  chk_pin_status:
    assert property (avs_read && !avs_waitrequest && avs_address == 8'h0c
      |-> avs_readdata[3:0] == $past(module_output_pin)) else $error("pin status mismatch");
  chk_reset_quiet:
    assert property ($fell(srst) |-> module_output_pin == 4'h0 && avs_readdata == 32'h0)
      else $error("outputs not clear after reset");
  chk_low_clear:
    assert property (wack && avs_address == {4'h1, pwm_array_pkg::OFF_COMPARE_LOW}
      |-> ##2 !module_output_pin[0]) else $error("pin high after compare low write");
  chk_mode_off:
    assert property (wack && avs_address == 8'h10 && !(avs_writedata[6] && avs_writedata[1])
      |-> ##2 !module_output_pin[0]) else $error("pin high with mode off");
endmodule // pwm_array_asserts
bind pwm_array pwm_array_asserts chk_u (.clk, .srst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .module_output_pin);
`default_nettype wire

// ### test/test_pwm_array.sv
// Purpose: self-checking bench for the pwm counter array
// Assumes: timebases clk, clk/4, clk/12 and external pin
// Notes:   expected high counts carry the one-clock pin lag
`timescale 1ns/1ps
`default_nettype none
module test_pwm_array;
  // ********************
  // bench
  // ********************
  logic        clk, srst, avs_read, avs_write, ext_tick_pin, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable, module_output_pin;
  int          failures, compares, cyc, rises;
  int          hi[4];
  pwm_array dut_u (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .ext_tick_pin, .avs_readdata, .avs_waitrequest, .module_output_pin);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // long enough for the /12 pass with margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= ~w;
    // request stands until waitrequest is seen low at a rising edge
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(n, q, {24'h0, e});
  endtask
  function automatic logic [7:0] ma(input int m, input logic [3:0] off);
    return {4'(m + 1), off};
  endfunction
  task automatic meas(input int n);
    logic prev;
    hi = '{default: 0};
    rises = 0;
    @(negedge clk);
    prev = module_output_pin[0];
    repeat (n) begin
      @(negedge clk);
      for (int m = 0; m < 4; m++) hi[m] += int'(module_output_pin[m]);
      rises += int'(module_output_pin[0] & ~prev);
      prev = module_output_pin[0];
    end
  endtask
  task automatic t_regs();
    rd("control", 8'h00, 8'h00);
    rd("mode0", ma(0, pwm_array_pkg::OFF_MODE), 8'h00);
    wr(8'h08, 8'h5a);
    bus(1'b1, 8'h08, 8'h11, 4'h0);
    rd("cnt_high", 8'h08, 8'h5a);
    rd("unmapped", 8'hf0, 8'h00);
    wr(8'h0c, 8'h0f);
    rd("pin_status", 8'h0c, 8'h00);
    wr(ma(1, pwm_array_pkg::OFF_MODE), 8'h42);
    // counter stopped at zero equals compare low zero
    rd("pin_on", 8'h0c, 8'h02);
    wr(ma(1, pwm_array_pkg::OFF_COMPARE_LOW), 8'h33);
    rd("mode_low", ma(1, pwm_array_pkg::OFF_MODE), 8'h02);
    wr(ma(1, pwm_array_pkg::OFF_COMPARE_HIGH), 8'h80);
    rd("mode_high", ma(1, pwm_array_pkg::OFF_MODE), 8'h42);
  endtask
  task automatic t_pwm();
    int d[3] = '{1, 4, 12};
    wr(ma(0, pwm_array_pkg::OFF_COMPARE_LOW), 8'hc0);
    wr(ma(0, pwm_array_pkg::OFF_COMPARE_HIGH), 8'hc0);
    wr(ma(0, pwm_array_pkg::OFF_MODE), 8'h42);
    wr(ma(2, pwm_array_pkg::OFF_MODE), 8'h40);
    wr(ma(3, pwm_array_pkg::OFF_MODE), 8'h02);
    wr(8'h04, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 8'(2 * i + 1));
      repeat (300 * d[i]) @(posedge clk);
      meas(512 * d[i]);
      chk("rises", rises, 2);
      chk("high2", hi[2], 0);
      chk("high3", hi[3], 0);
    end
    wr(8'h00, 8'h01);
    repeat (300) @(posedge clk);
    meas(512);
    chk("high0", hi[0], 2 * (256 - 'hc0 - 1));
    chk("high1", hi[1], 2 * (256 - 'h80 - 1));
  endtask
  task automatic t_reload();
    wr(ma(0, pwm_array_pkg::OFF_COMPARE_HIGH), 8'h40);
    repeat (300) @(posedge clk);
    rd("reload", ma(0, pwm_array_pkg::OFF_COMPARE_LOW), 8'h40);
    meas(512);
    chk("high_new", hi[0], 2 * (256 - 'h40 - 1));
    wr(ma(0, pwm_array_pkg::OFF_COMPARE_LOW), 8'h40);
    meas(512);
    chk("high_off", hi[0], 0);
    chk("high_other", hi[1], 2 * (256 - 'h80 - 1));
    wr(ma(0, pwm_array_pkg::OFF_COMPARE_HIGH), 8'h40);
    repeat (300) @(posedge clk);
    wr(ma(0, pwm_array_pkg::OFF_MODE), 8'h40);
    meas(512);
    chk("high_mode_off", hi[0], 0);
  endtask
  task automatic t_ext();
    wr(8'h00, 8'h06);
    wr(8'h04, 8'hfe);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h07);
    repeat (3) begin
      @(posedge clk);
      ext_tick_pin <= 1'b1;
      repeat (2) @(posedge clk);
      ext_tick_pin <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    rd("ext_low", 8'h04, 8'h01);
    rd("ext_high", 8'h08, 8'h01);
  endtask
  initial begin
    {srst, avs_read, avs_write, ext_tick_pin} = 4'h8;
    {avs_address, avs_writedata, avs_byteenable} = '0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_pwm();
    t_reload();
    t_ext();
    give_verdict();
  end
endmodule // test_pwm_array
`default_nettype wire
